// ==== lrsb_partner.sv ====
// Purpose: Load unit model returning data lat cycles after grant
// Assumes: Returns in grant order
// Notes:   Idle dest toggles so it is never trusted
`timescale 1ns/1ps
module lrsb_partner (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  issueGo,
  input wire lrsb_pkg::lrsb_issue_t issue,
  input wire logic [7:0]            lat,
  output lrsb_pkg::lrsb_wb_t        wb
);
  logic [4:0] dq[$];
  int         tq[$];
  int         cyc;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq = {};
      tq = {};
      cyc = 0;
      wb = '0;
    end else begin
      cyc++;
      // The decoder drops valid as soon as it sees the grant, so only the held fields qualify it
      if (issueGo && issue.isLoad) begin
        dq.push_back(issue.dest);
        tq.push_back(cyc + lat);
      end
      #1;
      wb.valid = tq.size() > 0 && tq[0] <= cyc;
      wb.dest = wb.valid ? dq.pop_front() : ~wb.dest;
      if (wb.valid) void'(tq.pop_front());
    end
  end
endmodule : lrsb_partner

// ==== lrsb_pkg.sv ====
// Purpose: Shared constants and carrier types for the load register scoreboard
// Assumes: One processor clock, 32 visible registers, three load slots
// Notes:   Used through scoped names only
package lrsb_pkg;
  localparam int REG_COUNT   = 32;   // Sixteen global plus sixteen local
  localparam int REG_IDX_W   = 5;
  localparam int SLOT_COUNT  = 3;    // Outstanding loads at once
  localparam int SRC_COUNT   = 3;    // Operand references per instruction
  localparam logic [REG_COUNT-1:0] BUSY_RESET = 32'h0000_0000;

  // Issue request from the decoder
  typedef struct packed {
    logic                 valid;
    logic                 isLoad;     // A memory_load_instruction
    logic [REG_IDX_W-1:0] dest;
    logic [SRC_COUNT-1:0] srcUsed;
    logic [REG_IDX_W-1:0] src2;
    logic [REG_IDX_W-1:0] src1;
    logic [REG_IDX_W-1:0] src0;
  } lrsb_issue_t;

  // Load data write-back from the load unit
  typedef struct packed {
    logic                 valid;
    logic [REG_IDX_W-1:0] dest;
  } lrsb_wb_t;

  // Slot state
  typedef enum logic { LRSB_SLOT_FREE, LRSB_SLOT_PENDING } lrsb_slot_t;
endpackage : lrsb_pkg

// ==== lrsb_slot.sv ====
// Purpose: One load tracking slot holding a pending destination register
// Assumes: At most one allocate and one write-back per cycle
// Notes:   Frees itself when write-back names its register
`timescale 1ns/1ps
module lrsb_slot (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         alloc,
  input  wire logic [lrsb_pkg::REG_IDX_W-1:0] allocDest,
  input  wire lrsb_pkg::lrsb_wb_t           wb,
  output lrsb_pkg::lrsb_slot_t              state,
  output logic [lrsb_pkg::REG_IDX_W-1:0]    dest
);
  lrsb_pkg::lrsb_slot_t                 state_q;
  logic [lrsb_pkg::REG_IDX_W-1:0]       dest_q;

  // Slot state machine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= lrsb_pkg::LRSB_SLOT_FREE;
    end else begin
      case (state_q)
        lrsb_pkg::LRSB_SLOT_FREE: begin
          if (alloc) begin
            state_q <= lrsb_pkg::LRSB_SLOT_PENDING;
          end
        end
        lrsb_pkg::LRSB_SLOT_PENDING: begin
          if (wb.valid && wb.dest == dest_q) begin
            state_q <= lrsb_pkg::LRSB_SLOT_FREE;
          end
        end
        default: state_q <= lrsb_pkg::LRSB_SLOT_FREE;
      endcase
    end
  end

  // Destination capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dest_q <= '0;
    end else if (alloc) begin
      dest_q <= allocDest;
    end
  end

  assign state = state_q;
  assign dest  = dest_q;
endmodule : lrsb_slot

// ==== lrsb_top.sv ====
// Purpose: Busy scoreboard for registers targeted by outstanding memory loads
// Assumes: Decoder holds a request until issueGo; load unit reports each write-back once
// Notes:   Verdicts are registered, so a request is answered the cycle after it appears
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - A starting load sets the busy flag of its destination register.
// - Load data write-back clears that register's busy flag.
// - Instructions reading a busy register, and loads writing one, are held until clear.
// - Instructions touching no busy register issue while loads are pending.
// - Up to three loads may be outstanding, each with its flag set.
// - Tracking covers all 32 visible registers, global and local.
module lrsb_top #(
  parameter int SLOTS = lrsb_pkg::SLOT_COUNT
) (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire lrsb_pkg::lrsb_issue_t            issue,
  input  wire lrsb_pkg::lrsb_wb_t               wb,
  output logic                                  issueGo,
  output logic                                  issueHold,
  output logic [lrsb_pkg::REG_COUNT-1:0]        busyVec,
  output logic [$clog2(SLOTS+1)-1:0]            pendingCount
);
  localparam int CW = $clog2(SLOTS+1);

  ////////////////////////////////////////////////////////////////////////////
  // Slots
  logic [SLOTS-1:0]                       slotAlloc;
  logic [SLOTS-1:0]                       slotFree;
  lrsb_pkg::lrsb_slot_t                   slotState [SLOTS];
  logic [lrsb_pkg::REG_IDX_W-1:0]         slotDest  [SLOTS];
  logic [lrsb_pkg::REG_COUNT-1:0]         busy;
  logic [lrsb_pkg::REG_COUNT-1:0]         touch;
  logic [SLOTS-1:0]                       firstFree;
  logic                                   anyFree;
  logic                                   conflict;
  logic                                   go;
  logic                                   issueGo_q;
  logic                                   issueHold_q;
  logic [lrsb_pkg::REG_COUNT-1:0]         busyVec_q;
  logic [CW-1:0]                          pendingCount_q;
  logic [CW-1:0]                          count_d;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : gSlot
      lrsb_slot uSlot (
        .clk       (clk),
        .nrst      (nrst),
        .alloc     (slotAlloc[g]),
        .allocDest (issue.dest),
        .wb        (wb),
        .state     (slotState[g]),
        .dest      (slotDest[g])
      );
      assign slotFree[g] = (slotState[g] == lrsb_pkg::LRSB_SLOT_FREE);
    end
  endgenerate

  always_comb begin
    busy = lrsb_pkg::BUSY_RESET;
    for (int i = 0; i < SLOTS; i++) begin
      if (slotState[i] == lrsb_pkg::LRSB_SLOT_PENDING) begin
        busy[slotDest[i]] = 1'b1;
      end
    end
  end

  // Registers the request reads, plus the destination of a load
  always_comb begin
    touch = '0;
    if (issue.srcUsed[0]) touch[issue.src0] = 1'b1;
    if (issue.srcUsed[1]) touch[issue.src1] = 1'b1;
    if (issue.srcUsed[2]) touch[issue.src2] = 1'b1;
    if (issue.isLoad) touch[issue.dest] = 1'b1;
  end

  // Lowest free slot
  always_comb begin
    firstFree = '0;
    anyFree   = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (slotFree[i] && !anyFree) begin
        firstFree[i] = 1'b1;
        anyFree      = 1'b1;
      end
    end
  end

  assign conflict = |(touch & busy);
  assign go = issue.valid && !conflict && !issueGo_q && (!issue.isLoad || anyFree);

  ////////////////////////////////////////////////////////////////////////////
  // allocate on load start
  assign slotAlloc = (go && issue.isLoad) ? firstFree : '0;

  // Issue verdict; one cycle gap after a grant lets the decoder advance
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      issueGo_q   <= 1'b0;
      issueHold_q <= 1'b0;
    end else begin
      issueGo_q   <= go;
      issueHold_q <= issue.valid && !go && !issueGo_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busyVec_q <= lrsb_pkg::BUSY_RESET;
    end else begin
      busyVec_q <= busy;
    end
  end

  // Pending load count
  always_comb begin
    count_d = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (!slotFree[i]) count_d = count_d + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendingCount_q <= '0;
    end else begin
      pendingCount_q <= count_d;
    end
  end

  assign issueGo      = issueGo_q;
  assign issueHold    = issueHold_q;
  assign busyVec      = busyVec_q;
  assign pendingCount = pendingCount_q;
endmodule : lrsb_top

// ==== lrsb_top_asserts.sv ====
// Purpose: Port checker for the load scoreboard
// Assumes: busyVec and pendingCount lag state by one cycle
// Notes:   Bound into lrsb_top
`timescale 1ns/1ps
module lrsb_top_asserts #(
  parameter int SLOTS = 3
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire lrsb_pkg::lrsb_issue_t issue,
  input wire lrsb_pkg::lrsb_wb_t    wb,
  input wire logic                  issueGo,
  input wire logic                  issueHold,
  input wire logic [31:0]           busyVec,
  input wire logic [$clog2(SLOTS+1)-1:0] pendingCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic opBusy;
  // Any used operand shown busy
  assign opBusy = (issue.srcUsed[0] && busyVec[issue.src0]) || (issue.srcUsed[1] && busyVec[issue.src1])
                || (issue.srcUsed[2] && busyVec[issue.src2]);
  a_go_single: assert property (issueGo |=> !issueGo) else $error("issueGo twice");
  a_go_not_hold: assert property (!(issueGo && issueHold)) else $error("go with hold");
  a_load_marks: assert property (issueGo && issue.isLoad |=> busyVec[$past(issue.dest)]) else $error("no mark");
  a_wb_clears: assert property (wb.valid |-> ##2 !busyVec[$past(wb.dest, 2)]) else $error("mark kept");
  a_busy_holds: assert property (issue.valid && opBusy && !issueGo && !$past(wb.valid)
    |=> issueHold) else $error("busy operand went");
  a_free_issues: assert property (issue.valid && !issue.isLoad && !opBusy && !issueGo
    |=> issueGo) else $error("free op held");
  a_count_match: assert property (pendingCount == $countones(busyVec)) else $error("count off");
  a_full_holds: assert property (issue.valid && issue.isLoad && pendingCount == SLOTS && !$past(wb.valid)
    && !issueGo |=> issueHold) else $error("fourth load went");
  c_full: cover property (pendingCount == SLOTS);
  c_hold: cover property (issueHold);
  c_wb: cover property (wb.valid);
endmodule : lrsb_top_asserts
bind lrsb_top lrsb_top_asserts #(.SLOTS(SLOTS)) i_chk (.clk(clk), .nrst(nrst), .issue(issue), .wb(wb),
  .issueGo(issueGo), .issueHold(issueHold), .busyVec(busyVec), .pendingCount(pendingCount));

// ==== lrsb_top_tb.sv ====
// Purpose: Scenario bench for the load scoreboard
// Assumes: Decoder drops a request after issueGo
// Notes:   Inputs change 1 ns after the edge
`timescale 1ns/1ps
module lrsb_top_tb;
  logic clk = 0, nrst = 0, issueGo, issueHold;
  logic [31:0] busyVec;
  logic [1:0] pendingCount;
  logic [7:0] lat = 8'h04;
  lrsb_pkg::lrsb_issue_t issue = '0;
  lrsb_pkg::lrsb_wb_t wb;
  int errors = 0, checks_done = 0, cyc = 0, n, h;
  always #50 clk = ~clk;
  lrsb_top i_dut (.clk(clk), .nrst(nrst), .issue(issue), .wb(wb), .issueGo(issueGo), .issueHold(issueHold),
    .busyVec(busyVec), .pendingCount(pendingCount));
  lrsb_partner i_ldu (.clk(clk), .nrst(nrst), .issueGo(issueGo), .issue(issue), .lat(lat), .wb(wb));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  // Hold one request until granted; n counts cycles
  task req(input logic ld, input logic [4:0] d, input logic [2:0] u, input logic [4:0] s);
    @(posedge clk);
    #1 issue = {1'b1, ld, d, u, s, s, s};
    n = 0;
    h = 0;
    do begin
      @(posedge clk);
      #1 n++;
      if (issueHold === 1'b1) h++;
    end while (issueGo !== 1'b1 && n < 400);
    issue.valid = 1'b0;
  endtask : req
  task t_use;
    lat = 8'h06;
    req(1'b1, 5'h04, 3'h0, 5'h00);
    @(posedge clk);
    #1 chk(busyVec[4], "r4 not busy");
    req(1'b0, 5'h00, 3'h1, 5'h04);
    chk(n > 2 && n < 12, "use not held");
    chk(h == n - 1, "hold not shown each stalled cycle");
    chk(busyVec[4] === 1'b0, "r4 stays busy");
    $display("t_use done");
  endtask : t_use
  task t_free;
    lat = 8'hc8;
    req(1'b1, 5'h05, 3'h0, 5'h00);
    req(1'b0, 5'h00, 3'h7, 5'h01);
    chk(n == 1 && busyVec[5], "free op held");
    repeat (210) @(posedge clk);
    #1 chk(pendingCount === 2'h0, "not drained");
    $display("t_free done");
  endtask : t_free
  task t_full;
    lat = 8'h28;
    req(1'b1, 5'h00, 3'h0, 5'h00);
    req(1'b1, 5'h10, 3'h0, 5'h00);
    req(1'b1, 5'h1f, 3'h0, 5'h00);
    @(posedge clk);
    #1 chk(pendingCount === 2'h3 && busyVec === 32'h8001_0001, "three not pending");
    req(1'b1, 5'h07, 3'h0, 5'h00);
    chk(n > 25 && n < 45, "fourth not held");
    chk(h == n - 1, "fourth hold not shown");
    $display("t_full done");
  endtask : t_full
  task test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_use;
    t_free;
    t_full;
    test_done;
  end
endmodule : lrsb_top_tb
